// [logic/dcc_pkg.sv]
package dcc_pkg;
    localparam int NCH = 32;
    localparam int NTMR = 4;
    localparam int NSRC = 36;
    localparam int TW = 16;
    localparam int AW = 8;
    localparam int DW = 32;

    // register map, one 32-bit register per address on the plain port
    localparam logic [7:0] CH_VAL_BASE = 8'h00;
    localparam logic [7:0] CH_CFG_BASE = 8'h20;
    localparam logic [7:0] TMR_CNT_BASE = 8'h40;
    localparam logic [7:0] TMR_REL_BASE = 8'h44;
    localparam logic [7:0] TMR_CTL_BASE = 8'h48;
    localparam logic [7:0] ST_CH_ADDR = 8'h50;
    localparam logic [7:0] ST_TMR_ADDR = 8'h51;
    localparam logic [7:0] MSK_CH_ADDR = 8'h52;
    localparam logic [7:0] MSK_TMR_ADDR = 8'h53;
    localparam logic [7:0] VEC_ADDR = 8'h54;

    // channel configuration field layout
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_TSEL_BIT = 4;
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_RISE = 4'h1;
    localparam logic [3:0] MODE_CAP_FALL = 4'h2;
    localparam logic [3:0] MODE_CAP_BOTH = 4'h3;
    localparam logic [3:0] MODE_CMP_FLAG = 4'h4;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h5;
    localparam logic [3:0] MODE_CMP_ONCE = 4'h6;
    localparam logic [3:0] MODE_CMP_SET = 4'h7;
    localparam logic [3:0] MODE_CMP_CLR = 4'h8;

    // timer control field layout
    localparam int TCTL_RUN_BIT = 0;
    localparam int TCTL_SEL_LSB = 1;
    localparam logic [2:0] TSRC_DIV_MAX = 3'h4;
    localparam logic [2:0] TSRC_AUX = 3'h5;
    localparam logic [2:0] TSRC_PIN = 3'h6;

    // vector register field layout
    localparam int VEC_VALID_BIT = 31;
    localparam int VEC_TRAP_LSB = 16;
    localparam int VEC_LOC_LSB = 0;

    // finest step: 125 ns at a 64 MHz core clock, i.e. a fixed cycle ratio
    localparam int RES_NS = 125;
    localparam int REF_MHZ = 64;
    localparam int BASE_DIV = (RES_NS * REF_MHZ) / 1000;
    localparam int CLK_NS = 40;
    localparam int DIV_W = 8;

    localparam logic [TW-1:0] TMR_MAX = 16'hFFFF;
    localparam logic [TW-1:0] RST_VAL = 16'h0000;

    typedef struct packed {
        logic tsel;
        logic [3:0] mode;
    } dcc_ch_cfg_t;

    typedef struct packed {
        logic [2:0] clk_sel;
        logic run;
    } dcc_tmr_ctl_t;

    typedef struct packed {
        logic valid;
        logic [7:0] trap;
        logic [9:0] loc;
    } dcc_vec_t;
endpackage : dcc_pkg

// [logic/dcc_top.sv]
// Notes on behaviour
// RQ1 - two arrays of sixteen channels, finest step eight base clocks
// RQ2 - four 16-bit timers with reload, two pairs, one per array
// RQ3 - timer clock from prescaled system clock or aux unit overflow
// RQ4 - first timer of each pair may count an external pin
// RQ5 - each channel picks timer of its pair and capture or compare
// RQ6 - each channel owns one pin: capture input or compare output
// RQ7 - capture copies allocated timer into the channel register
// RQ8 - each capture raises its own channel interrupt request
// RQ9 - capture edge selectable: rising, falling or both
// RQ10 - five compare modes, compared continuously against allocated timer
// RQ11 - on timer equal to register, perform selected compare action
// RQ12 - each channel and timer has flag, enable, vector and trap number
// RQ13 - outside party drives array1 timer a count pin when selected
// RQ14 - timer overflow loads reload value and keeps counting
`timescale 1ns/100ps
`default_nettype none
module dcc_top
    import dcc_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic [AW-1:0] ADDR_I,
    input wire logic [DW-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [DW-1:0] RDATA_O,
    output logic IRQ_O,
    input wire logic [NCH-1:0] CC_PIN_I,
    output logic [NCH-1:0] CC_PIN_O,
    output logic [NCH-1:0] CC_PIN_OE_O,
    input wire logic [1:0] COUNT_PIN_I,
    input wire logic AUX_OVF_I
);

    function automatic logic is_capture(input logic [3:0] m);
        is_capture = (m == MODE_CAP_RISE) || (m == MODE_CAP_FALL) || (m == MODE_CAP_BOTH);
    endfunction : is_capture

    function automatic logic is_compare(input logic [3:0] m);
        is_compare = (m >= MODE_CMP_FLAG) && (m <= MODE_CMP_CLR);
    endfunction : is_compare

    function automatic logic drives_pin(input logic [3:0] m);
        drives_pin = (m == MODE_CMP_TOGGLE) || (m == MODE_CMP_SET) || (m == MODE_CMP_CLR);
    endfunction : drives_pin

    // timer index from channel number and its timer select
    function automatic logic [1:0] tmr_of(input int ch, input logic tsel);
        tmr_of = {ch >= 16, tsel};
    endfunction : tmr_of

    function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
        div_mask = DIV_W'((BASE_DIV << sel) - 1);
    endfunction : div_mask

    // sources 0..31 channels, 32..35 timers
    function automatic logic [7:0] trap_of(input logic [5:0] src);
        logic [7:0] s;
        s = {2'b00, src};
        if (src < 6'd16) begin
            trap_of = s + 8'h10;
        end else if (src < 6'd29) begin
            trap_of = s + 8'h20;
        end else if (src < 6'd32) begin
            trap_of = s + 8'h27;
        end else if (src == 6'd32) begin
            trap_of = 8'h20;
        end else if (src == 6'd33) begin
            trap_of = 8'h21;
        end else if (src == 6'd34) begin
            trap_of = 8'h3D;
        end else begin
            trap_of = 8'h3E;
        end
    endfunction : trap_of

    logic [NCH-1:0] pin_s1_reg;
    logic [NCH-1:0] pin_s2_reg;
    logic [NCH-1:0] pin_s3_reg;
    logic [1:0] cnt_s1_reg;
    logic [1:0] cnt_s2_reg;
    logic [1:0] cnt_s3_reg;
    logic [DIV_W-1:0] div_reg;
    logic [TW-1:0] tmr_reg [NTMR];
    logic [TW-1:0] rel_reg [NTMR];
    dcc_tmr_ctl_t tctl_reg [NTMR];
    logic [NTMR-1:0] step_reg;
    logic [NTMR-1:0] ovf_reg;
    logic [TW-1:0] val_reg [NCH];
    dcc_ch_cfg_t cfg_reg [NCH];
    logic [NCH-1:0] armed_reg;
    logic [NCH-1:0] pin_out_reg;
    logic [NCH-1:0] pin_oe_reg;
    logic [NCH-1:0] st_ch_reg;
    logic [NTMR-1:0] st_tmr_reg;
    logic [NCH-1:0] msk_ch_reg;
    logic [NTMR-1:0] msk_tmr_reg;
    logic [DW-1:0] rdata_reg;
    logic irq_reg;

    logic [NTMR-1:0] tick;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] cmp_ev;
    logic [1:0] cnt_edge;
    dcc_vec_t vec_next;

    logic [AW-1:0] idx;
    assign idx = ADDR_I;

    // pins are asynchronous; stage three only feeds the edge detector
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            cnt_s1_reg <= '0;
            cnt_s2_reg <= '0;
            cnt_s3_reg <= '0;
        end else begin
            pin_s1_reg <= CC_PIN_I;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            cnt_s1_reg <= COUNT_PIN_I; // [RQ13]
            cnt_s2_reg <= cnt_s1_reg;
            cnt_s3_reg <= cnt_s2_reg;
        end
    end

    assign cnt_edge = cnt_s2_reg & ~cnt_s3_reg;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DIV_W'(1);
        end
    end

    always_comb begin
        for (int t = 0; t < NTMR; t++) begin
            if (!tctl_reg[t].run) begin
                tick[t] = 1'b0;
            end else if (tctl_reg[t].clk_sel <= TSRC_DIV_MAX) begin
                tick[t] = (div_reg & div_mask(tctl_reg[t].clk_sel)) == div_mask(tctl_reg[t].clk_sel); // [RQ1] [RQ3]
            end else if (tctl_reg[t].clk_sel == TSRC_AUX) begin
                tick[t] = AUX_OVF_I; // [RQ3]
            end else if (tctl_reg[t].clk_sel == TSRC_PIN && t % 2 == 0) begin
                tick[t] = cnt_edge[t / 2]; // [RQ4]
            end else begin
                tick[t] = 1'b0;
            end
        end
    end

    // timers; a software write of the count wins over a tick
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int t = 0; t < NTMR; t++) begin
                tmr_reg[t] <= RST_VAL;
                rel_reg[t] <= RST_VAL;
                tctl_reg[t] <= '0;
            end
            step_reg <= '0;
            ovf_reg <= '0;
        end else begin
            for (int t = 0; t < NTMR; t++) begin
                step_reg[t] <= 1'b0;
                ovf_reg[t] <= 1'b0;
                if (WR_I && idx == TMR_REL_BASE + AW'(t)) begin
                    rel_reg[t] <= WDATA_I[TW-1:0];
                end
                if (WR_I && idx == TMR_CTL_BASE + AW'(t)) begin
                    tctl_reg[t] <= WDATA_I[3:0];
                end
                if (WR_I && idx == TMR_CNT_BASE + AW'(t)) begin
                    tmr_reg[t] <= WDATA_I[TW-1:0];
                end else if (tick[t]) begin
                    step_reg[t] <= 1'b1;
                    if (tmr_reg[t] == TMR_MAX) begin
                        tmr_reg[t] <= rel_reg[t]; // [RQ2] [RQ14]
                        ovf_reg[t] <= 1'b1;
                    end else begin
                        tmr_reg[t] <= tmr_reg[t] + 16'h0001; // [RQ2]
                    end
                end
            end
        end
    end

    // compare fires once per timer step, not on every cycle the value sits
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            cap_ev[c] = 1'b0;
            cmp_ev[c] = 1'b0;
            case (cfg_reg[c].mode)
                MODE_CAP_RISE: cap_ev[c] = pin_s2_reg[c] & ~pin_s3_reg[c]; // [RQ9]
                MODE_CAP_FALL: cap_ev[c] = ~pin_s2_reg[c] & pin_s3_reg[c]; // [RQ9]
                MODE_CAP_BOTH: cap_ev[c] = pin_s2_reg[c] ^ pin_s3_reg[c]; // [RQ9]
                default: cap_ev[c] = 1'b0;
            endcase
            if (is_compare(cfg_reg[c].mode) && step_reg[tmr_of(c, cfg_reg[c].tsel)]) begin
                cmp_ev[c] = tmr_reg[tmr_of(c, cfg_reg[c].tsel)] == val_reg[c]; // [RQ5] [RQ10]
                if (cfg_reg[c].mode == MODE_CMP_ONCE) begin
                    cmp_ev[c] = cmp_ev[c] & armed_reg[c];
                end
            end
        end
    end

    // channel registers; a capture wins over a software write
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int c = 0; c < NCH; c++) begin
                val_reg[c] <= RST_VAL;
                cfg_reg[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (WR_I && idx == CH_CFG_BASE + AW'(c)) begin
                    cfg_reg[c] <= {WDATA_I[CFG_TSEL_BIT], WDATA_I[CFG_MODE_LSB +: 4]}; // [RQ5]
                end
                if (cap_ev[c]) begin
                    val_reg[c] <= tmr_reg[tmr_of(c, cfg_reg[c].tsel)]; // [RQ7]
                end else if (WR_I && idx == CH_VAL_BASE + AW'(c)) begin
                    val_reg[c] <= WDATA_I[TW-1:0];
                end
            end
        end
    end

    // compare actions on the channel pins
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pin_out_reg <= '0;
            pin_oe_reg <= '0;
            armed_reg <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                pin_oe_reg[c] <= drives_pin(cfg_reg[c].mode); // [RQ6]
                if (ovf_reg[tmr_of(c, cfg_reg[c].tsel)] || !is_compare(cfg_reg[c].mode)) begin
                    armed_reg[c] <= 1'b1;
                end else if (cmp_ev[c]) begin
                    armed_reg[c] <= 1'b0;
                end
                case (cfg_reg[c].mode)
                    MODE_CMP_TOGGLE: begin
                        if (cmp_ev[c]) begin
                            pin_out_reg[c] <= ~pin_out_reg[c]; // [RQ11]
                        end
                    end
                    MODE_CMP_SET: begin
                        if (cmp_ev[c]) begin
                            pin_out_reg[c] <= 1'b1; // [RQ11]
                        end else if (ovf_reg[tmr_of(c, cfg_reg[c].tsel)]) begin
                            pin_out_reg[c] <= 1'b0;
                        end
                    end
                    MODE_CMP_CLR: begin
                        if (cmp_ev[c]) begin
                            pin_out_reg[c] <= 1'b0; // [RQ11]
                        end else if (ovf_reg[tmr_of(c, cfg_reg[c].tsel)]) begin
                            pin_out_reg[c] <= 1'b1;
                        end
                    end
                    default: pin_out_reg[c] <= pin_out_reg[c];
                endcase
            end
        end
    end

    // sticky flags: a new event in the clearing read's cycle survives
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_ch_reg <= '0;
            st_tmr_reg <= '0;
        end else begin
            st_ch_reg <= (st_ch_reg & ~{NCH{RD_I && idx == ST_CH_ADDR}}) | cap_ev | cmp_ev; // [RQ8] [RQ12]
            st_tmr_reg <= (st_tmr_reg & ~{NTMR{RD_I && idx == ST_TMR_ADDR}}) | ovf_reg; // [RQ12]
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            msk_ch_reg <= '0;
            msk_tmr_reg <= '0;
        end else begin
            if (WR_I && idx == MSK_CH_ADDR) begin
                msk_ch_reg <= WDATA_I[NCH-1:0];
            end
            if (WR_I && idx == MSK_TMR_ADDR) begin
                msk_tmr_reg <= WDATA_I[NTMR-1:0];
            end
        end
    end

    // lowest pending enabled source wins the vector
    always_comb begin
        logic [NSRC-1:0] pend;
        pend = {st_tmr_reg & msk_tmr_reg, st_ch_reg & msk_ch_reg};
        vec_next = '0;
        for (int s = NSRC - 1; s >= 0; s--) begin
            if (pend[s]) begin
                vec_next.valid = 1'b1;
                vec_next.trap = trap_of(6'(s)); // [RQ12]
                vec_next.loc = {trap_of(6'(s)), 2'b00};
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |{st_tmr_reg & msk_tmr_reg, st_ch_reg & msk_ch_reg};
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= '0;
            if (RD_I) begin
                if (idx < CH_CFG_BASE) begin
                    rdata_reg <= {16'h0000, val_reg[idx[4:0]]};
                end else if (idx < TMR_CNT_BASE) begin
                    rdata_reg <= {27'h0, cfg_reg[idx[4:0]]};
                end else if (idx < TMR_REL_BASE) begin
                    rdata_reg <= {16'h0000, tmr_reg[idx[1:0]]};
                end else if (idx < TMR_CTL_BASE) begin
                    rdata_reg <= {16'h0000, rel_reg[idx[1:0]]};
                end else if (idx < TMR_CTL_BASE + 8'h04) begin
                    rdata_reg <= {28'h0000000, tctl_reg[idx[1:0]]};
                end else if (idx == ST_CH_ADDR) begin
                    rdata_reg <= st_ch_reg;
                end else if (idx == ST_TMR_ADDR) begin
                    rdata_reg <= {28'h0000000, st_tmr_reg};
                end else if (idx == MSK_CH_ADDR) begin
                    rdata_reg <= msk_ch_reg;
                end else if (idx == MSK_TMR_ADDR) begin
                    rdata_reg <= {28'h0000000, msk_tmr_reg};
                end else if (idx == VEC_ADDR) begin
                    rdata_reg[VEC_VALID_BIT] <= vec_next.valid;
                    rdata_reg[VEC_TRAP_LSB +: 8] <= vec_next.trap;
                    rdata_reg[VEC_LOC_LSB +: 10] <= vec_next.loc;
                end
            end
        end
    end

    assign RDATA_O = rdata_reg;
    assign IRQ_O = irq_reg;
    assign CC_PIN_O = pin_out_reg;
    assign CC_PIN_OE_O = pin_oe_reg;

endmodule : dcc_top
`default_nettype wire

// [test/dcc_far.sv]
`timescale 1ns/100ps
`default_nettype none
module dcc_far
    import dcc_pkg::*;
(
    input wire logic clk_i,
    input wire logic [NCH-1:0] pin_o_i,
    input wire logic [NCH-1:0] pin_oe_i,
    output logic [NCH-1:0] pin_i_o,
    output logic [1:0] count_o,
    output logic aux_o
);
    logic [NCH-1:0] ext_lvl;

    // a driven pin reads back what the block drives, else the outside level
    assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_lvl);

    initial begin
        ext_lvl = '0;
        count_o = '0;
        aux_o = 1'b0;
    end

    // hold long enough for the input synchroniser and edge stage
    task automatic set_pin(input int ch, input logic lvl);
        @(posedge clk_i);
        ext_lvl[ch] <= lvl;
        repeat (8) @(posedge clk_i);
    endtask : set_pin

    task automatic pulse_aux(input int n);
        repeat (n) begin
            @(posedge clk_i);
            aux_o <= 1'b1;
            @(posedge clk_i);
            aux_o <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
    endtask : pulse_aux

    // count pin is asynchronous, so each level stands several clocks
    task automatic pulse_cnt(input int i, input int n);
        repeat (n) begin
            @(posedge clk_i);
            count_o[i] <= 1'b1;
            repeat (4) @(posedge clk_i);
            count_o[i] <= 1'b0;
            repeat (4) @(posedge clk_i);
        end
    endtask : pulse_cnt
endmodule : dcc_far
`default_nettype wire

// [test/dcc_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module dcc_chk
    import dcc_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic [AW-1:0] ADDR_I,
    input wire logic [DW-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [DW-1:0] RDATA_O,
    input wire logic IRQ_O,
    input wire logic [NCH-1:0] CC_PIN_I,
    input wire logic [NCH-1:0] CC_PIN_O,
    input wire logic [NCH-1:0] CC_PIN_OE_O,
    input wire logic [1:0] COUNT_PIN_I,
    input wire logic AUX_OVF_I
);
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RSTN_I);

    // channel index taken back from the write two cycles earlier, no local variable needed
    property oe_follow(logic [3:0] m, logic lvl);
        WR_I && ADDR_I[7:5] == 3'b001 && WDATA_I[3:0] == m |-> ##2 CC_PIN_OE_O[$past(ADDR_I[4:0], 2)] == lvl;
    endproperty

    oe_toggle_on_a: assert property (oe_follow(MODE_CMP_TOGGLE, 1'b1)) else $error("toggle pin not driven");
    oe_set_on_a: assert property (oe_follow(MODE_CMP_SET, 1'b1)) else $error("set pin not driven");
    oe_clr_on_a: assert property (oe_follow(MODE_CMP_CLR, 1'b1)) else $error("clear pin not driven");
    oe_capture_off_a: assert property (oe_follow(MODE_CAP_RISE, 1'b0)) else $error("capture pin driven");
    rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == '0) else $error("read data outside slot");
    unmapped_zero_a: assert property ($past(RD_I) && $past(ADDR_I) > VEC_ADDR |-> RDATA_O == '0)
        else $error("unmapped read not zero");
    ch_width_a: assert property ($past(RD_I) && $past(ADDR_I) < CH_CFG_BASE |-> RDATA_O[31:16] == '0)
        else $error("channel value wider than timer");
    tmr_width_a: assert property ($past(RD_I) && $past(ADDR_I[7:3]) == 5'b01000 |-> RDATA_O[31:16] == '0)
        else $error("timer wider than 16 bits");
    tst_width_a: assert property ($past(RD_I) && $past(ADDR_I) == ST_TMR_ADDR |-> RDATA_O[31:4] == '0)
        else $error("timer status beyond four timers");
    vec_loc_a: assert property ($past(RD_I) && $past(ADDR_I) == VEC_ADDR && RDATA_O[VEC_VALID_BIT]
        |-> RDATA_O[9:0] == {RDATA_O[23:16], 2'b00}) else $error("vector location not trap times four");
    reset_out_a: assert property ($rose(RSTN_I) |-> RDATA_O == '0 && !IRQ_O && CC_PIN_OE_O == '0)
        else $error("outputs active after reset");

    cover property ($rose(IRQ_O));
    cover property ($past(RD_I) && $past(ADDR_I) == VEC_ADDR && RDATA_O[VEC_VALID_BIT]);
    cover property (|(CC_PIN_O & CC_PIN_OE_O));
endmodule : dcc_chk
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench
    import dcc_pkg::*;
;
    logic CLK_SYS_I, RSTN_I, WR_I, RD_I, IRQ_O, AUX_OVF_I, rd_q;
    logic [AW-1:0] ADDR_I;
    logic [DW-1:0] WDATA_I, RDATA_O;
    logic [NCH-1:0] CC_PIN_I, CC_PIN_O, CC_PIN_OE_O;
    logic [1:0] COUNT_PIN_I;
    logic [DW-1:0] exp_q[$];
    logic [15:0] va, vb;
    int fail_count, n_tests, cycles, seed;

    dcc_top DUT (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
        .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .CC_PIN_I(CC_PIN_I), .CC_PIN_O(CC_PIN_O),
        .CC_PIN_OE_O(CC_PIN_OE_O), .COUNT_PIN_I(COUNT_PIN_I), .AUX_OVF_I(AUX_OVF_I));
    dcc_far u_far (.clk_i(CLK_SYS_I), .pin_o_i(CC_PIN_O), .pin_oe_i(CC_PIN_OE_O), .pin_i_o(CC_PIN_I),
        .count_o(COUNT_PIN_I), .aux_o(AUX_OVF_I));

    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp(input string what, input logic [DW-1:0] e, input logic [DW-1:0] got);
        n_tests++;
        if (got !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask : cmp

    task automatic chk_pins(input logic [NCH-1:0] e);
        cmp("compare pins", e, CC_PIN_O & 32'h0000_1F00);
    endtask : chk_pins

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLK_SYS_I);
        WR_I <= 1'b0;
        @(posedge CLK_SYS_I);
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        exp_q.push_back(e);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLK_SYS_I);
        RD_I <= 1'b0;
        @(posedge CLK_SYS_I);
    endtask : rd

    initial begin
        CLK_SYS_I = 1'b0;
        forever #20 CLK_SYS_I = ~CLK_SYS_I;
    end

    // read data stand only in the slot after the strobe
    always @(posedge CLK_SYS_I) begin
        if (rd_q) begin
            cmp("read data", exp_q.pop_front(), RDATA_O);
        end
        rd_q <= RD_I;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        seed = 32'h70C7658A;
        RSTN_I = 1'b0;
        WR_I = 1'b0;
        RD_I = 1'b0;
        ADDR_I = '0;
        WDATA_I = '0;
        rd_q = 1'b0;
        fail_count = 0;
        n_tests = 0;
        cycles = 0;
        repeat (4) @(posedge CLK_SYS_I);
        RSTN_I <= 1'b1;
        @(posedge CLK_SYS_I);
        rd(TMR_CNT_BASE, 32'h0);
        rd(ST_CH_ADDR, 32'h0);
        rd(VEC_ADDR, 32'h0);
        rd(8'hFF, 32'h0);
        // timers stay stopped here so the captured value is exact
        for (int m = 1; m <= 3; m++) begin
            va = 16'($random(seed));
            vb = 16'($random(seed));
            wr(CH_CFG_BASE + 8'(m), DW'(m));
            wr(TMR_CNT_BASE, DW'(va));
            u_far.set_pin(m, 1'b1);
            rd(ST_CH_ADDR, DW'(m != 2) << m);
            wr(TMR_CNT_BASE, DW'(vb));
            u_far.set_pin(m, 1'b0);
            rd(CH_VAL_BASE + 8'(m), DW'((m == 1) ? va : vb));
            rd(ST_CH_ADDR, DW'(m != 1) << m);
        end
        wr(CH_CFG_BASE + 8'd20, DW'(MODE_CAP_RISE));
        wr(TMR_CNT_BASE + 8'd2, 32'h0000_0ABC);
        u_far.set_pin(20, 1'b1);
        cmp("masked irq", 32'h0, DW'(IRQ_O));
        wr(MSK_CH_ADDR, 32'h0010_0000);
        repeat (2) @(posedge CLK_SYS_I);
        cmp("irq", 32'h1, DW'(IRQ_O));
        rd(VEC_ADDR, 32'h8034_00D0);
        rd(CH_VAL_BASE + 8'd20, 32'h0000_0ABC);
        rd(ST_CH_ADDR, 32'h0010_0000);
        repeat (2) @(posedge CLK_SYS_I);
        cmp("cleared irq", 32'h0, DW'(IRQ_O));
        // one channel per compare mode, all on timer b of array0 stepped by aux pulses
        wr(TMR_REL_BASE + 8'd1, 32'h0000_0010);
        wr(TMR_CNT_BASE + 8'd1, 32'h0000_FFFC);
        for (int c = 8; c <= 12; c++) begin
            wr(CH_VAL_BASE + 8'(c), (c == 8) ? 32'h0000_FFFF : 32'h0000_FFFE);
            wr(CH_CFG_BASE + 8'(c), 32'h10 | DW'(c - 4));
        end
        wr(TMR_CTL_BASE + 8'd1, DW'({TSRC_AUX, 1'b1}));
        cmp("pin enables", 32'h0000_1A00, CC_PIN_OE_O & 32'h0000_1F00);
        u_far.pulse_aux(2);
        chk_pins(32'h0000_0A00);
        u_far.pulse_aux(2);
        chk_pins(32'h0000_1200);
        rd(TMR_CNT_BASE + 8'd1, 32'h0000_0010);
        rd(ST_TMR_ADDR, 32'h0000_0002);
        rd(ST_CH_ADDR, 32'h0000_1F00);
        for (int i = 0; i < 2; i++) begin
            wr(TMR_CNT_BASE + 8'(2 * i), 32'h0000_0100);
            wr(TMR_CTL_BASE + 8'(2 * i), DW'({TSRC_PIN, 1'b1}));
            u_far.pulse_cnt(i, i + 2);
            rd(TMR_CNT_BASE + 8'(2 * i), DW'(32'h0100 + i + 2));
        end
        // run window of two divider periods holds exactly two ticks, whatever the divider phase
        for (int s = 0; s <= 4; s++) begin
            wr(TMR_CNT_BASE + 8'd3, 32'h0);
            wr(TMR_CTL_BASE + 8'd3, DW'({3'(s), 1'b1}));
            repeat (2 * (BASE_DIV << s) - 2) @(posedge CLK_SYS_I);
            wr(TMR_CTL_BASE + 8'd3, 32'h0);
            rd(TMR_CNT_BASE + 8'd3, 32'h2);
        end
        end_of_test();
    end
endmodule : testbench

bind dcc_top dcc_chk u_chk (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .CC_PIN_I(CC_PIN_I), .CC_PIN_O(CC_PIN_O),
    .CC_PIN_OE_O(CC_PIN_OE_O), .COUNT_PIN_I(COUNT_PIN_I), .AUX_OVF_I(AUX_OVF_I));
`default_nettype wire
